// ### rtl/lcd_host_pkg.sv
package lcd_host_pkg;

    // ----------------------------------------------------------------
    // Widths and bit positions
    // ----------------------------------------------------------------
    localparam int          DATA_W       = 8;
    localparam int          NIB_W        = 4;
    localparam int          SER_DATA_BIT = 7;
    localparam int          SER_CLK_BIT  = 6;
    localparam int          BIT_CNT_W    = 3;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic [2:0]  BIT_CNT_RST  = 3'h0;
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;
    localparam logic [1:0]  STRAP_RST    = 2'h0;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic        SEL_CMD      = 1'b0;
    localparam logic        SEL_DATA     = 1'b1;
    localparam logic        STYLE_80     = 1'b0;
    localparam logic        STYLE_68     = 1'b1;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam logic [3:0]  NIB_RST      = 4'h0;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       cmd_data_select;
        logic       strobe;
        logic       port_parallel;
        logic       width_8bit;
        logic       initialize_pin;
        logic [7:0] data;
    } bus_pins_s;

    typedef struct packed {
        logic       is_data;
        logic [7:0] value;
    } xfer_s;

    localparam int         PINS_W    = $bits(bus_pins_s);
    // Idle bus: deselected, strobe high, parallel, 8-bit
    localparam bus_pins_s  PINS_IDLE = '{cs_n: 1'b1, cmd_data_select: 1'b0,
                                         strobe: 1'b1, port_parallel: 1'b1,
                                         width_8bit: 1'b1, initialize_pin: 1'b0,
                                         data: 8'h00};
    localparam xfer_s      XFER_RST  = '{is_data: 1'b0, value: 8'h00};

endpackage

// ### rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int                W       = 1,
    parameter logic [W-1:0]      RST_VAL = '0
) (
    input  wire logic            mclk_in,
    input  wire logic            sys_rst_in,
    input  wire logic [W-1:0]    async_in,
    output logic      [W-1:0]    sync_out
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            meta     <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // pin_sync

// ### rtl/serial_rx.sv
`timescale 1ns/1ps
module serial_rx (
    input  wire logic       mclk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       clear_in,
    input  wire logic       enable_in,
    input  wire logic       clk_rise_in,
    input  wire logic       bit_in,
    input  wire logic       sel_in,
    output logic            done_out,
    output logic [7:0]      byte_out,
    output logic            sel_out,
    output logic [2:0]      count_out
);
    logic [2:0] cnt;
    logic [7:0] shreg;
    logic [2:0] next_cnt;
    logic [7:0] next_shreg;
    logic       next_done;
    logic [7:0] next_byte;
    logic       next_sel;

    always_comb begin
        next_cnt   = cnt;
        next_shreg = shreg;
        next_done  = 1'b0;
        next_byte  = byte_out;
        next_sel   = sel_out;
        if (clear_in) begin
            next_cnt   = lcd_host_pkg::BIT_CNT_RST;
            next_shreg = lcd_host_pkg::BYTE_RST;
        end else if (enable_in && clk_rise_in) begin
            next_shreg = {shreg[6:0], bit_in};
            next_cnt   = cnt + 3'h1;
            if (cnt == lcd_host_pkg::LAST_BIT) begin
                next_done = 1'b1;
                next_byte = {shreg[6:0], bit_in};
                next_sel  = sel_in;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            cnt      <= lcd_host_pkg::BIT_CNT_RST;
            shreg    <= lcd_host_pkg::BYTE_RST;
            done_out <= 1'b0;
            byte_out <= lcd_host_pkg::BYTE_RST;
            sel_out  <= lcd_host_pkg::SEL_CMD;
        end else begin
            cnt      <= next_cnt;
            shreg    <= next_shreg;
            done_out <= next_done;
            byte_out <= next_byte;
            sel_out  <= next_sel;
        end
    end

    assign count_out = cnt;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ser_clear;
        @(posedge mclk_in) disable iff (sys_rst_in)
        clear_in |=> (cnt == lcd_host_pkg::BIT_CNT_RST) && (shreg == lcd_host_pkg::BYTE_RST);
    endproperty
    a_ser_clear: assert property (p_ser_clear)
        else $error("serial state not cleared");

    property p_ser_done;
        @(posedge mclk_in) disable iff (sys_rst_in)
        done_out |-> $past(cnt) == lcd_host_pkg::LAST_BIT
                     && cnt == lcd_host_pkg::BIT_CNT_RST && $past(enable_in);
    endproperty
    a_ser_done: assert property (p_ser_done)
        else $error("byte done without eighth bit");

    property p_ser_msb;
        @(posedge mclk_in) disable iff (sys_rst_in)
        (!clear_in && enable_in && clk_rise_in) |=> shreg[0] == $past(bit_in);
    endproperty
    a_ser_msb: assert property (p_ser_msb)
        else $error("serial bit not shifted in");

    c_ser_byte: cover property (@(posedge mclk_in) disable iff (sys_rst_in) done_out);
endmodule // serial_rx

// ### rtl/lcd_host_write_interface.sv
`timescale 1ns/1ps
module lcd_host_write_interface (
    input  wire logic                     mclk_in,
    input  wire logic                     sys_rst_in,
    input  wire lcd_host_pkg::bus_pins_s  pins_in,
    output lcd_host_pkg::xfer_s           xfer_out,
    output logic                          byte_valid_out,
    output logic                          cmd_write_out,
    output logic                          data_write_out,
    output logic                          init_pulse_out,
    output logic                          style_68_out,
    output logic                          nibble_pending_out
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [lcd_host_pkg::PINS_W-1:0] pins_sync;
    lcd_host_pkg::bus_pins_s         s;
    lcd_host_pkg::bus_pins_s         q;

    pin_sync #(
        .W       (lcd_host_pkg::PINS_W),
        .RST_VAL (lcd_host_pkg::PINS_IDLE)
    ) u_pin_sync (
        .mclk_in    (mclk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   (pins_in),
        .sync_out   (pins_sync)
    );

    assign s = lcd_host_pkg::bus_pins_s'(pins_sync);

    // Previous sample, for edge finding and for data held at the edge
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            q <= lcd_host_pkg::PINS_IDLE;
        end else begin
            q <= s;
        end
    end

    // ----------------------------------------------------------------
    // Event decode
    // ----------------------------------------------------------------
    logic [1:0] strap_cnt;
    logic       strap_taken;
    logic       init_edge;
    logic       wr_rise;
    logic       en_fall;
    logic       par_take;
    logic       ser_rise;
    logic       ser_clear;
    logic       ser_enable;

    // Strap only once both sync stages hold real pin levels
    assign strap_taken = (strap_cnt == lcd_host_pkg::STRAP_WAIT);
    // Either direction initializes; chip select plays no part
    assign init_edge   = strap_taken && (s.initialize_pin != q.initialize_pin);
    assign wr_rise     = !q.strobe && s.strobe;
    // Enable high qualifies; byte taken as enable drops
    assign en_fall     = q.strobe && !s.strobe;
    assign par_take    = strap_taken && !init_edge && q.port_parallel
                         && !q.cs_n
                         && (style_68_out ? en_fall : wr_rise);
    assign ser_rise    = !q.data[lcd_host_pkg::SER_CLK_BIT]
                         && s.data[lcd_host_pkg::SER_CLK_BIT];
    assign ser_enable  = strap_taken && !s.port_parallel && !s.cs_n;
    assign ser_clear   = s.cs_n || s.port_parallel || init_edge;

    // ----------------------------------------------------------------
    // Serial receiver
    // ----------------------------------------------------------------
    logic       ser_done;
    logic [7:0] ser_byte;
    logic       ser_sel;
    logic [2:0] ser_count;

    serial_rx u_serial_rx (
        .mclk_in     (mclk_in),
        .sys_rst_in  (sys_rst_in),
        .clear_in    (ser_clear),
        .enable_in   (ser_enable),
        .clk_rise_in (ser_rise),
        .bit_in      (s.data[lcd_host_pkg::SER_DATA_BIT]),
        .sel_in      (s.cmd_data_select),
        .done_out    (ser_done),
        .byte_out    (ser_byte),
        .sel_out     (ser_sel),
        .count_out   (ser_count)
    );

    // ----------------------------------------------------------------
    // Parallel capture, nibble pairing, output stage
    // ----------------------------------------------------------------
    logic [3:0]          nib_hi;
    logic [1:0]          next_strap_cnt;
    logic [3:0]          next_nib_hi;
    logic                next_nibble_pending;
    logic                next_style_68;
    logic                next_init_pulse;
    logic                next_byte_valid;
    lcd_host_pkg::xfer_s next_xfer;

    always_comb begin
        next_strap_cnt      = strap_cnt;
        next_nib_hi         = nib_hi;
        next_nibble_pending = nibble_pending_out;
        next_style_68       = style_68_out;
        next_init_pulse     = 1'b0;
        next_byte_valid     = 1'b0;
        next_xfer           = xfer_out;
        if (!strap_taken) begin
            next_strap_cnt = strap_cnt + 2'h1;
            if (strap_cnt == lcd_host_pkg::STRAP_WAIT - 2'h1) begin
                next_style_68 = s.initialize_pin;
            end
        end else if (init_edge) begin
            // Level after the edge picks the style, whichever way it moved
            next_init_pulse     = 1'b1;
            next_style_68       = s.initialize_pin;
            next_nibble_pending = 1'b0;
        end else if (par_take) begin
            if (q.width_8bit) begin
                next_byte_valid = 1'b1;
                next_xfer       = '{is_data: q.cmd_data_select, value: q.data};
            end else if (!nibble_pending_out) begin
                next_nib_hi         = q.data[7:4];
                next_nibble_pending = 1'b1;
            end else begin
                next_byte_valid     = 1'b1;
                next_nibble_pending = 1'b0;
                next_xfer           = '{is_data: q.cmd_data_select,
                                        value:   {nib_hi, q.data[7:4]}};
            end
        end else if (ser_done) begin
            next_byte_valid = 1'b1;
            next_xfer       = '{is_data: ser_sel, value: ser_byte};
        end
        // A half byte is stale once the bus leaves 4-bit parallel
        if (s.width_8bit || !s.port_parallel) begin
            next_nibble_pending = 1'b0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            strap_cnt          <= lcd_host_pkg::STRAP_RST;
            nib_hi             <= lcd_host_pkg::NIB_RST;
            nibble_pending_out <= 1'b0;
            style_68_out       <= lcd_host_pkg::STYLE_80;
            init_pulse_out     <= 1'b0;
            byte_valid_out     <= 1'b0;
            cmd_write_out      <= 1'b0;
            data_write_out     <= 1'b0;
            xfer_out           <= lcd_host_pkg::XFER_RST;
        end else begin
            strap_cnt          <= next_strap_cnt;
            nib_hi             <= next_nib_hi;
            nibble_pending_out <= next_nibble_pending;
            style_68_out       <= next_style_68;
            init_pulse_out     <= next_init_pulse;
            byte_valid_out     <= next_byte_valid;
            cmd_write_out      <= next_byte_valid && (next_xfer.is_data == lcd_host_pkg::SEL_CMD);
            data_write_out     <= next_byte_valid && (next_xfer.is_data == lcd_host_pkg::SEL_DATA);
            xfer_out           <= next_xfer;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (sys_rst_in);

    property p_init_pulse;
        init_edge |=> init_pulse_out && !byte_valid_out;
    endproperty
    a_init_pulse: assert property (p_init_pulse)
        else $error("initialize edge not acted on");

    property p_style_level;
        init_edge |=> style_68_out == $past(s.initialize_pin);
    endproperty
    a_style_level: assert property (p_style_level)
        else $error("bus style does not follow pin level");

    property p_style_hold;
        (strap_taken && !init_edge) |=> $stable(style_68_out);
    endproperty
    a_style_hold: assert property (p_style_hold)
        else $error("bus style changed without initialize edge");

    property p_cs_gate;
        ($past(q.cs_n) && s.cs_n && q.cs_n) |=> !byte_valid_out;
    endproperty
    a_cs_gate: assert property (p_cs_gate)
        else $error("byte accepted while deselected");

    property p_wr80_byte;
        (strap_taken && !init_edge && !style_68_out && q.port_parallel && !q.cs_n
         && q.width_8bit && wr_rise)
        |=> byte_valid_out && xfer_out.value == $past(q.data)
            && xfer_out.is_data == $past(q.cmd_data_select);
    endproperty
    a_wr80_byte: assert property (p_wr80_byte)
        else $error("80-style byte not latched on strobe rise");

    property p_en68_byte;
        (strap_taken && !init_edge && style_68_out && q.port_parallel && !q.cs_n
         && q.width_8bit && en_fall) |=> byte_valid_out;
    endproperty
    a_en68_byte: assert property (p_en68_byte)
        else $error("68-style enable pulse not taken");

    property p_kind;
        byte_valid_out |-> cmd_write_out != data_write_out
                           && data_write_out == xfer_out.is_data;
    endproperty
    a_kind: assert property (p_kind)
        else $error("write kind disagrees with select");

    property p_nibble_first;
        (par_take && !q.width_8bit && !nibble_pending_out)
        |=> !byte_valid_out && nib_hi == $past(q.data[7:4]);
    endproperty
    a_nibble_first: assert property (p_nibble_first)
        else $error("first nibble completed a byte");

    property p_nibble_pair;
        (par_take && !q.width_8bit && nibble_pending_out && !s.width_8bit)
        |=> byte_valid_out && xfer_out.value == {$past(nib_hi), $past(q.data[7:4])};
    endproperty
    a_nibble_pair: assert property (p_nibble_pair)
        else $error("nibbles paired in wrong order");

    property p_serial_mode;
        (byte_valid_out && !$past(par_take))
        |-> $past(ser_done) && ser_count == lcd_host_pkg::BIT_CNT_RST;
    endproperty
    a_serial_mode: assert property (p_serial_mode)
        else $error("serial byte without eight clocks");

    property p_serial_deselect;
        (s.cs_n && !init_edge) ##1 s.cs_n |-> ser_count == lcd_host_pkg::BIT_CNT_RST;
    endproperty
    a_serial_deselect: assert property (p_serial_deselect)
        else $error("serial counter kept while deselected");

    property p_nibble_drop;
        (s.width_8bit || !s.port_parallel) |=> !nibble_pending_out;
    endproperty
    a_nibble_drop: assert property (p_nibble_drop)
        else $error("stale nibble kept outside 4-bit parallel");

    property p_init_nibble;
        init_edge |=> !nibble_pending_out;
    endproperty
    a_init_nibble: assert property (p_init_nibble)
        else $error("half byte survived initialize");

    property p_init_any_cs;
        (init_edge && s.cs_n) |=> init_pulse_out;
    endproperty
    a_init_any_cs: assert property (p_init_any_cs)
        else $error("initialize ignored while deselected");

    property p_ser_byte;
        (ser_done && !par_take && !init_edge)
        |=> byte_valid_out && xfer_out.value == $past(ser_byte)
            && xfer_out.is_data == $past(ser_sel);
    endproperty
    a_ser_byte: assert property (p_ser_byte)
        else $error("serial byte or select not handed over");

    property p_serial_no_par;
        (!q.port_parallel && !ser_done) |=> !byte_valid_out;
    endproperty
    a_serial_no_par: assert property (p_serial_no_par)
        else $error("parallel byte taken in serial mode");

    c_byte_80: cover property (byte_valid_out && !style_68_out && nibble_pending_out == 1'b0);
    c_byte_68: cover property (byte_valid_out && style_68_out);
    c_nibble:  cover property (nibble_pending_out ##[1:40] byte_valid_out);
    c_init:    cover property (init_pulse_out ##1 style_68_out);
endmodule // lcd_host_write_interface

// ### test/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic               mclk_in,
    output lcd_host_pkg::bus_pins_s pins_out
);
    // ------------------------------------------------------------
    // Host pins, changed just after the falling edge
    // ------------------------------------------------------------
    logic style_68;

    initial begin
        pins_out = lcd_host_pkg::PINS_IDLE;
        style_68 = lcd_host_pkg::STYLE_80;
    end

    task automatic hold(input int n);
        repeat (n) @(negedge mclk_in);
    endtask

    // Mode pins are straps; settle them well before the next transfer
    task automatic set_mode(input logic par, input logic w8);
        hold(1);
        pins_out.port_parallel = par;
        pins_out.width_8bit    = w8;
        hold(8);
    endtask

    // Either edge initializes; strobe idle level follows the new style
    task automatic init_to(input logic lvl);
        hold(1);
        pins_out.initialize_pin = lvl;
        hold(2);
        style_68        = lvl;
        pins_out.strobe = ~lvl;
        hold(12);
    endtask

    task automatic par_write(input logic cs, input logic sel, input logic [7:0] d);
        hold(1);
        pins_out.cs_n            = ~cs;
        pins_out.cmd_data_select = sel;
        pins_out.data            = d;
        pins_out.strobe          = style_68;
        hold(4);
        pins_out.strobe = ~style_68;
        hold(4);
        pins_out.cs_n = 1'b1;
        // Released bus shows the inverse, never a stale copy
        pins_out.data = ~d;
        hold(4);
    endtask

    // Serial clock stands low outside frames; nbits below 8 leaves a partial byte
    task automatic ser_byte(input logic sel, input logic [7:0] d, input int nbits);
        hold(1);
        pins_out.cs_n      = 1'b0;
        pins_out.data[6]   = 1'b0;
        pins_out.data[5:0] = 6'h00;
        hold(4);
        for (int i = 0; i < nbits; i++) begin
            pins_out.data[7]         = d[7-i];
            pins_out.cmd_data_select = sel;
            hold(4);
            pins_out.data[6] = 1'b1;
            hold(4);
            pins_out.data[6] = 1'b0;
        end
        hold(4);
        pins_out.cs_n    = 1'b1;
        pins_out.data[7] = ~pins_out.data[7];
        hold(6);
    endtask
endmodule // host_bus_model

// ### test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic                    mclk_in;
    logic                    sys_rst_in;
    lcd_host_pkg::bus_pins_s pins;
    lcd_host_pkg::xfer_s     xfer_out;
    logic                    byte_valid_out;
    logic                    cmd_write_out;
    logic                    data_write_out;
    logic                    init_pulse_out;
    logic                    style_68_out;
    logic                    nibble_pending_out;
    int                      failures;
    int                      compares;
    int                      cycles;
    int                      inits;
    lcd_host_pkg::xfer_s     got_q[$];

    lcd_host_write_interface lcd_host_write_interface_inst (
        .mclk_in            (mclk_in),
        .sys_rst_in         (sys_rst_in),
        .pins_in            (pins),
        .xfer_out           (xfer_out),
        .byte_valid_out     (byte_valid_out),
        .cmd_write_out      (cmd_write_out),
        .data_write_out     (data_write_out),
        .init_pulse_out     (init_pulse_out),
        .style_68_out       (style_68_out),
        .nibble_pending_out (nibble_pending_out)
    );

    host_bus_model host_bus_model_inst (
        .mclk_in  (mclk_in),
        .pins_out (pins)
    );

    initial begin
        mclk_in = 1'b0;
        forever #4 mclk_in = ~mclk_in;
    end

    // ------------------------------------------------------------
    // Compare tasks and closing report
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic check_byte(input logic sel, input logic [7:0] v);
        lcd_host_pkg::xfer_s got;
        int                  n;
        n = 0;
        while (got_q.size() == 0 && n < 40) begin
            @(negedge mclk_in);
            n++;
        end
        compares++;
        got = (got_q.size() == 0) ? 9'h1FF : got_q.pop_front();
        if (got !== {sel, v}) begin
            failures++;
            $display("MISMATCH xfer_out expected %0h seen %0h", {sel, v}, got);
        end
    endtask

    task automatic check_none();
        host_bus_model_inst.hold(20);
        compares++;
        if (got_q.size() != 0) begin
            failures++;
            $display("MISMATCH byte_count expected 0 seen %0d", got_q.size());
        end
        got_q.delete();
    endtask

    task automatic init_check(input logic lvl);
        int start;
        start = inits;
        host_bus_model_inst.init_to(lvl);
        check_bit("init_pulse_out", 1'b1, inits == start + 1);
        check_bit("style_68_out", lvl, style_68_out);
    endtask

    // Sampled mid-cycle, where registered pulses have settled
    always @(negedge mclk_in) begin
        cycles++;
        if (cycles >= 6000) begin
            failures++;
            stop_test();
        end
        if (byte_valid_out === 1'b1) begin
            got_q.push_back(xfer_out);
            check_bit("cmd_write_out", ~xfer_out.is_data, cmd_write_out);
            check_bit("data_write_out", xfer_out.is_data, data_write_out);
        end else begin
            check_bit("write_pulse", 1'b0, cmd_write_out | data_write_out);
        end
        if (init_pulse_out === 1'b1)
            inits++;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures   = 0;
        compares   = 0;
        cycles     = 0;
        inits      = 0;
        sys_rst_in = 1'b1;
        repeat (4) @(negedge mclk_in);
        sys_rst_in = 1'b0;
        host_bus_model_inst.hold(10);
        check_bit("style_68_out", lcd_host_pkg::STYLE_80, style_68_out);
        check_bit("nibble_pending_out", 1'b0, nibble_pending_out);
        check_bit("xfer_is_data", 1'b0, xfer_out.is_data);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'hA5);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_DATA, 8'h3C);
        check_byte(lcd_host_pkg::SEL_CMD, 8'hA5);
        check_byte(lcd_host_pkg::SEL_DATA, 8'h3C);
        host_bus_model_inst.par_write(1'b0, lcd_host_pkg::SEL_DATA, 8'hFF);
        check_none();
        host_bus_model_inst.set_mode(1'b1, 1'b0);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'h96);
        check_bit("nibble_pending_out", 1'b1, nibble_pending_out);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_DATA, 8'h69);
        check_byte(lcd_host_pkg::SEL_DATA, 8'h96);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'h78);
        init_check(1'b1);
        check_bit("nibble_pending_out", 1'b0, nibble_pending_out);
        check_none();
        host_bus_model_inst.set_mode(1'b1, 1'b1);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_DATA, 8'h5A);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'h00);
        check_byte(lcd_host_pkg::SEL_DATA, 8'h5A);
        check_byte(lcd_host_pkg::SEL_CMD, 8'h00);
        host_bus_model_inst.set_mode(1'b1, 1'b0);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'h4B);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'hD2);
        check_byte(lcd_host_pkg::SEL_CMD, 8'h4D);
        init_check(1'b0);
        host_bus_model_inst.set_mode(1'b0, 1'b1);
        host_bus_model_inst.ser_byte(lcd_host_pkg::SEL_DATA, 8'hC3, 8);
        check_byte(lcd_host_pkg::SEL_DATA, 8'hC3);
        host_bus_model_inst.ser_byte(lcd_host_pkg::SEL_DATA, 8'hF0, 5);
        host_bus_model_inst.ser_byte(lcd_host_pkg::SEL_CMD, 8'h81, 8);
        check_byte(lcd_host_pkg::SEL_CMD, 8'h81);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'h24);
        check_none();
        host_bus_model_inst.set_mode(1'b1, 1'b1);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_DATA, 8'hE7);
        check_byte(lcd_host_pkg::SEL_DATA, 8'hE7);
        host_bus_model_inst.par_write(1'b1, lcd_host_pkg::SEL_CMD, 8'hA5);
        check_byte(lcd_host_pkg::SEL_CMD, 8'hA5);
        stop_test();
    end
endmodule // testbench
